// ---- src/sci_top.sv ----
`timescale 1ns/1ps
module sci_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire sci_pkg::sci_setup_t nv_rdata,
  output logic nv_we,
  output sci_pkg::sci_setup_t nv_wdata,
  output logic [2:0] baud_sel,
  output logic write_enabled,
  output logic restart_pulse,
  output logic [7:0] resp_sum
);
  import sci_pkg::*;

  sci_state_t state_reg;
  sci_setup_t setup_reg;
  logic [7:0] addr_active_reg;
  logic lf_active_reg;
  logic par_en_reg;
  logic par_odd_reg;
  logic [2:0] baud_reg;
  logic unlock_reg;
  logic [7:0] cmd_buf [0:BUF_DEPTH-1];
  logic [3:0] cnt_reg;
  logic ovf_reg;
  logic perr_reg;
  sci_err_t err_reg;
  logic [7:0] body_buf [0:8];
  logic [3:0] body_len_reg;
  logic [3:0] tx_idx_reg;
  logic tx_valid_reg;
  logic [7:0] tx_data_reg;
  logic nv_we_reg;
  logic restart_reg;
  logic [7:0] sum_reg;

  logic [7:0] ch;
  logic rx_perr;
  logic is_we;
  logic is_su;
  logic is_rsu;
  logic is_rr;
  logic hex_ok;
  sci_setup_t new_setup;
  logic addr_bad;
  sci_err_t err_next;
  logic [3:0] tx_total;
  logic [7:0] next_char;
  logic tx_free;

  function automatic logic is_hex(input logic [7:0] c);
    return (c >= CH_0 && c <= CH_9) || (c >= CH_A && c <= CH_F);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    logic [7:0] v;
    v = (c <= CH_9) ? c - CH_0 : c - HEX_LETTER_OFS;
    return v[3:0];
  endfunction

  function automatic logic [7:0] to_hex(input logic [3:0] n);
    return (n < 4'hA) ? CH_0 + {4'h0, n} : HEX_LETTER_OFS + {4'h0, n};
  endfunction

  // received character stripped of its parity bit, and its parity check
  assign ch = {1'b0, rx_data[6:0]};
  assign rx_perr = par_en_reg && ((^rx_data) != par_odd_reg);

  // command decode over the collected body
  always_comb begin
    is_we = cnt_reg == LEN_TWO && cmd_buf[0] == CH_W && cmd_buf[1] == CH_E;
    is_su = cnt_reg >= LEN_TWO && cmd_buf[0] == CH_S && cmd_buf[1] == CH_U;
    is_rsu = cmd_buf[0] == CH_R && cmd_buf[1] == CH_S
      && (cnt_reg == LEN_TWO || (cnt_reg == LEN_THREE && cmd_buf[2] == CH_U));
    is_rr = cnt_reg == LEN_TWO && cmd_buf[0] == CH_R && cmd_buf[1] == CH_R;
    hex_ok = (cnt_reg == SU_LEN) && !ovf_reg;
    for (int i = 2; i < BUF_DEPTH; i++) begin
      if (!is_hex(cmd_buf[i])) begin
        hex_ok = 1'b0;
      end
    end
  end

  // operand to setup bytes, high nibble first, byte one first
  always_comb begin
    new_setup = setup_reg;
    new_setup = {hex_val(cmd_buf[2]), hex_val(cmd_buf[3]), hex_val(cmd_buf[4]), hex_val(cmd_buf[5]),
                 hex_val(cmd_buf[6]), hex_val(cmd_buf[7]), hex_val(cmd_buf[8]), hex_val(cmd_buf[9])};
    addr_bad = new_setup.address[ADDR_MSB_BIT]
      || new_setup.address == CH_NUL || new_setup.address == CH_CR
      || new_setup.address == CH_DOLLAR || new_setup.address == CH_HASH;
  end

  // error priority: parity, unknown, write protect, syntax, address
  always_comb begin
    err_next = ERR_NONE;
    if (perr_reg) begin
      err_next = ERR_PAR;
    end else if (!(is_we || is_su || is_rsu || is_rr)) begin
      err_next = ERR_CMD;
    end else if ((is_su || is_rr) && !unlock_reg) begin
      err_next = ERR_WP;
    end else if (is_su && !hex_ok) begin
      err_next = ERR_SYNTAX;
    end else if (is_su && addr_bad) begin
      err_next = ERR_ADDR;
    end
  end

  // response framing: optional linefeed, body, carriage return, optional linefeed
  always_comb begin
    tx_total = body_len_reg + (lf_active_reg ? 4'h3 : 4'h1);
    next_char = CH_CR;
    if (lf_active_reg) begin
      if (tx_idx_reg == 4'h0 || tx_idx_reg == body_len_reg + 4'h2) begin
        next_char = CH_LF;
      end else if (tx_idx_reg <= body_len_reg) begin
        next_char = body_buf[tx_idx_reg - 4'h1];
      end
    end else if (tx_idx_reg < body_len_reg) begin
      next_char = body_buf[tx_idx_reg];
    end
  end

  assign tx_free = !tx_valid_reg || tx_ready;

  // parser state machine
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= ST_PROMPT;
    end else begin
      case (state_reg)
        ST_PROMPT: if (rx_valid && (ch == CH_DOLLAR || ch == CH_HASH)) state_reg <= ST_ADDR;
        ST_ADDR: if (rx_valid) state_reg <= (ch == addr_active_reg) ? ST_BODY : ST_SKIP;
        ST_BODY: if (rx_valid && ch == CH_CR) state_reg <= ST_EVAL;
        ST_SKIP: if (rx_valid && ch == CH_CR) state_reg <= ST_PROMPT;
        ST_EVAL: state_reg <= ST_RESP;
        ST_RESP: if (tx_free && tx_idx_reg == tx_total) state_reg <= ST_PROMPT;
        default: state_reg <= ST_PROMPT;
      endcase
    end
  end

  // body collection and parity tracking
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_reg <= 4'h0;
      ovf_reg <= 1'b0;
      perr_reg <= 1'b0;
    end else if (rx_valid && state_reg == ST_PROMPT) begin
      cnt_reg <= 4'h0;
      ovf_reg <= 1'b0;
      perr_reg <= rx_perr;
    end else if (rx_valid && (state_reg == ST_ADDR || state_reg == ST_BODY)) begin
      perr_reg <= perr_reg | rx_perr;
      if (state_reg == ST_BODY && ch != CH_CR) begin
        if (cnt_reg <= BODY_MAX) begin
          cnt_reg <= cnt_reg + 4'h1;
        end else begin
          ovf_reg <= 1'b1;
        end
      end
    end
  end

  // command buffer entries
  for (genvar gi = 0; gi < BUF_DEPTH; gi++) begin : g_buf
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        cmd_buf[gi] <= CH_NUL;
      end else if (rx_valid && state_reg == ST_BODY && ch != CH_CR && cnt_reg == 4'(gi)) begin
        cmd_buf[gi] <= ch;
      end
    end
  end

  // stored setup, commit only after full validation
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      setup_reg <= nv_rdata;
      nv_we_reg <= 1'b0;
    end else begin
      nv_we_reg <= 1'b0;
      if (state_reg == ST_EVAL && is_su && err_next == ERR_NONE) begin
        setup_reg <= new_setup;
        nv_we_reg <= 1'b1;
      end
    end
  end

  // write-unlock state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      unlock_reg <= 1'b0;
    end else if (state_reg == ST_EVAL) begin
      if (err_next == ERR_NONE) begin
        unlock_reg <= is_we;
      end
    end
  end

  // error code and response body
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      err_reg <= ERR_NONE;
      body_len_reg <= 4'h0;
      for (int i = 0; i < 9; i++) begin
        body_buf[i] <= CH_NUL;
      end
    end else if (state_reg == ST_EVAL) begin
      err_reg <= err_next;
      body_buf[0] <= CH_STAR;
      body_len_reg <= 4'h1;
      if (err_next != ERR_NONE) begin
        body_buf[0] <= CH_QUEST;
        body_buf[1] <= addr_active_reg;
        body_buf[2] <= CH_SPACE;
        body_len_reg <= 4'h4;
        case (err_next)
          ERR_SYNTAX: body_buf[3] <= CH_S;
          ERR_ADDR: body_buf[3] <= CH_A;
          ERR_CMD: body_buf[3] <= CH_C;
          ERR_PAR: body_buf[3] <= CH_P;
          ERR_WP: body_buf[3] <= CH_W;
          default: body_buf[3] <= CH_QUEST;
        endcase
      end else if (is_rsu) begin
        body_len_reg <= 4'h9;
        for (int i = 0; i < 8; i++) begin
          body_buf[i + 1] <= to_hex(setup_reg[31 - 4 * i -: 4]);
        end
      end
    end
  end

  // transmitter handshake, parity on the active setting
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg <= CH_NUL;
      tx_idx_reg <= 4'h0;
    end else if (state_reg == ST_EVAL) begin
      tx_idx_reg <= 4'h0;
    end else if (state_reg == ST_RESP && tx_free) begin
      if (tx_idx_reg < tx_total) begin
        tx_valid_reg <= 1'b1;
        tx_data_reg <= {par_en_reg & ((^next_char[6:0]) ^ par_odd_reg), next_char[6:0]};
        tx_idx_reg <= tx_idx_reg + 4'h1;
      end else begin
        tx_valid_reg <= 1'b0;
      end
    end
  end

  // running response sum, linefeeds excluded
  always_ff @(posedge clk) begin
    if (!rst_b || state_reg == ST_EVAL) begin
      sum_reg <= 8'h00;
    end else if (tx_valid_reg && tx_ready && tx_data_reg[6:0] != CH_LF[6:0]) begin
      sum_reg <= sum_reg + {1'b0, tx_data_reg[6:0]};
    end
  end

  // live settings, swapped in only after the reply is out
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_active_reg <= nv_rdata.address;
      lf_active_reg <= nv_rdata.comm[LF_BIT];
      par_en_reg <= nv_rdata.comm[PAR_EN_BIT];
      par_odd_reg <= nv_rdata.comm[PAR_ODD_BIT];
    end else if (state_reg == ST_RESP && tx_free && tx_idx_reg == tx_total) begin
      addr_active_reg <= setup_reg.address;
      lf_active_reg <= setup_reg.comm[LF_BIT];
      par_en_reg <= setup_reg.comm[PAR_EN_BIT];
      par_odd_reg <= setup_reg.comm[PAR_ODD_BIT];
    end
  end

  // baud selection follows only reset or remote restart
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      baud_reg <= nv_rdata.comm[BAUD_MSB:BAUD_LSB];
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (state_reg == ST_EVAL && is_rr && err_next == ERR_NONE) begin
        baud_reg <= setup_reg.comm[BAUD_MSB:BAUD_LSB];
        restart_reg <= 1'b1;
      end
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign nv_we = nv_we_reg;
  assign nv_wdata = setup_reg;
  assign baud_sel = baud_reg;
  assign write_enabled = unlock_reg;
  assign restart_pulse = restart_reg;
  assign resp_sum = sum_reg;

  a_locked_su_refused: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_EVAL && is_su && !unlock_reg && !perr_reg |=> err_reg == ERR_WP && !nv_we_reg)
    else $error("setup-write accepted while locked");
  a_unlock_cleared: assert property (@(posedge clk) disable iff (!rst_b)
    nv_we_reg |-> !unlock_reg)
    else $error("unlock survived a completed write");
  a_unlock_kept: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_EVAL && unlock_reg && err_next != ERR_NONE |=> unlock_reg)
    else $error("unlock lost on error");
  a_operand_stored: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_EVAL && is_su && err_next == ERR_NONE |=> setup_reg == $past(new_setup) && nv_we_reg)
    else $error("operand not stored");
  a_bad_addr_kept: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_EVAL && is_su && unlock_reg && hex_ok && !perr_reg && addr_bad
    |=> err_reg == ERR_ADDR && $stable(setup_reg))
    else $error("illegal address stored");
  a_no_lf_off: assert property (@(posedge clk) disable iff (!rst_b)
    tx_valid_reg && !lf_active_reg |-> tx_data_reg[6:0] != CH_LF[6:0])
    else $error("linefeed sent while disabled");
  a_tx_parity: assert property (@(posedge clk) disable iff (!rst_b)
    tx_valid_reg |-> tx_data_reg[PARITY_BIT] == (par_en_reg & ((^tx_data_reg[6:0]) ^ par_odd_reg)))
    else $error("transmit parity wrong");
  a_parity_reply: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_EVAL && perr_reg |=> err_reg == ERR_PAR && !nv_we_reg && !restart_reg)
    else $error("parity error not reported");
  a_settings_hold: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_RESP && tx_valid_reg && tx_idx_reg != tx_total
    |=> $stable(par_en_reg) && $stable(par_odd_reg) && $stable(lf_active_reg) && $stable(addr_active_reg))
    else $error("settings changed mid reply");
  a_sum_skips_lf: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_RESP && tx_valid_reg && tx_ready && tx_data_reg[6:0] == CH_LF[6:0] |=> $stable(sum_reg))
    else $error("linefeed counted in sum");

endmodule // sci_top

// ---- src/sci_pkg.sv ----
package sci_pkg;

  // setup bytes, in order of transfer
  typedef struct packed {
    logic [7:0] address;
    logic [7:0] comm;
    logic [7:0] options;
    logic [7:0] word_len;
  } sci_setup_t;

  // one-hot parser states
  typedef enum logic [5:0] {
    ST_PROMPT = 6'b000001,
    ST_ADDR   = 6'b000010,
    ST_BODY   = 6'b000100,
    ST_SKIP   = 6'b001000,
    ST_EVAL   = 6'b010000,
    ST_RESP   = 6'b100000
  } sci_state_t;

  typedef enum logic [2:0] {
    ERR_NONE   = 3'h0,
    ERR_SYNTAX = 3'h1,
    ERR_ADDR   = 3'h2,
    ERR_CMD    = 3'h3,
    ERR_PAR    = 3'h4,
    ERR_WP     = 3'h5
  } sci_err_t;

  // characters
  localparam logic [7:0] CH_NUL = 8'h00;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_QUEST = 8'h3F;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] HEX_LETTER_OFS = 8'h37;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_W = 8'h57;

  // field positions
  localparam int ADDR_MSB_BIT = 7;
  localparam int LF_BIT = 7;
  localparam int PAR_ODD_BIT = 6;
  localparam int PAR_EN_BIT = 5;
  localparam int BAUD_LSB = 0;
  localparam int BAUD_MSB = 2;
  localparam int PARITY_BIT = 7;

  // command buffer and operand
  localparam int BUF_DEPTH = 10;
  localparam logic [3:0] SU_LEN = 4'hA;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [3:0] LEN_THREE = 4'h3;
  localparam logic [3:0] BODY_MAX = 4'h9;
  localparam logic [31:0] SETUP_RESET = 32'h31070102;

endpackage

// ---- tb/sci_host_model.sv ----
`timescale 1ns/1ps
module sci_host_model (
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  import sci_pkg::*;
  // host framing settings, set by the bench to match what the host believes
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  logic slow = 1'b0;
  logic [7:0] got[$];
  int cyc = 0;

  // idle line, ready receiver
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end

  // slow mode takes one character in four cycles
  always @(negedge clk) begin
    cyc++;
    tx_ready <= !slow || (cyc % 4 == 0);
  end

  // collect every accepted reply character
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready) begin
      got.push_back(tx_data);
    end
  end

  // one character pulse; bad flips the parity bit on purpose
  task automatic send_char(input logic [7:0] c, input logic bad);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = {(par_en & ((^c[6:0]) ^ par_odd)) ^ bad, c[6:0]};
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // released line shows no stale value
  endtask

  // whole command then a carriage return; the char at bad_idx goes out with its parity bit flipped
  task automatic send_cmd(input string s, input int bad_idx);
    for (int i = 0; i < s.len(); i++) begin
      send_char(s[i], i == bad_idx);
    end
    send_char(CH_CR, 1'b0);
  endtask
endmodule // sci_host_model

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import sci_pkg::*;
  logic clk, rst_b, rx_valid, tx_ready, tx_valid, nv_we, write_enabled, restart_pulse;
  logic [7:0] rx_data, tx_data, resp_sum;
  logic [2:0] baud_sel;
  sci_setup_t nv_rdata, nv_wdata;
  int failures = 0;
  int n_compared = 0;
  int n_we = 0;
  int n_restart = 0;
  string bad_addr[5] = '{"00", "0D", "24", "23", "80"};
  string bad_syn[4] = '{"$1SU3107010", "$1SU310701020", "$1SU31X70102", "$1SU3107010a"};

  `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end

  sci_top dut (.clk, .rst_b, .rx_valid, .rx_data, .tx_ready, .tx_valid, .tx_data, .nv_rdata,
    .nv_we, .nv_wdata, .baud_sel, .write_enabled, .restart_pulse, .resp_sum);

  sci_host_model host (.clk, .tx_valid, .tx_data, .rx_valid, .rx_data, .tx_ready);

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // storage model and pulse counters
  always @(posedge clk) begin
    if (nv_we === 1'b1) begin
      nv_rdata <= nv_wdata;
      n_we++;
    end
    if (restart_pulse === 1'b1) n_restart++;
  end

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // waits for a reply, checks framing, parity of every char and the reply sum
  task automatic expect_resp(input string body, input logic lf, input logic en, input logic odd);
    logic [7:0] q[$];
    logic [7:0] sum;
    int k;
    sum = 8'h00;
    k = 0;
    if (lf) q.push_back(CH_LF);
    for (int i = 0; i < body.len(); i++) q.push_back(body[i]);
    q.push_back(CH_CR);
    if (lf) q.push_back(CH_LF);
    while (host.got.size() < q.size() && k < 600) begin
      @(negedge clk);
      k++;
    end
    repeat (8) @(negedge clk);
    `CHK(host.got.size(), q.size())
    foreach (q[i]) begin
      if (q[i] != CH_LF) sum += {1'b0, q[i][6:0]};
      if (i < host.got.size()) `CHK(host.got[i], {en & ((^q[i][6:0]) ^ odd), q[i][6:0]})
    end
    `CHK(resp_sum, sum)
    host.got.delete();
  endtask

  task automatic reset_dut();
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
  endtask

  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    nv_rdata = SETUP_RESET;
    reset_dut();
    `CHK(nv_wdata, SETUP_RESET)
    `CHK(baud_sel, 3'h7)
    `CHK(write_enabled, 1'b0)
    host.send_cmd("$1RSU", -1); // read before writing
    expect_resp("*31070102", 1'b0, 1'b0, 1'b0);
    host.send_cmd("$1SU32070102", -1);
    expect_resp("?1 W", 1'b0, 1'b0, 1'b0);
    host.send_cmd("$1WE", 2); // wrong parity bit ignored while off
    expect_resp("*", 1'b0, 1'b0, 1'b0);
    `CHK(write_enabled, 1'b1)
    foreach (bad_addr[i]) begin
      host.send_cmd({"$1SU", bad_addr[i], "070102"}, -1);
      expect_resp("?1 A", 1'b0, 1'b0, 1'b0);
    end
    foreach (bad_syn[i]) begin
      host.send_cmd(bad_syn[i], -1);
      expect_resp("?1 S", 1'b0, 1'b0, 1'b0);
    end
    host.send_cmd("$1XY", -1);
    expect_resp("?1 C", 1'b0, 1'b0, 1'b0);
    `CHK(write_enabled, 1'b1)
    `CHK(n_we, 0)
    `CHK(nv_wdata, SETUP_RESET)
    // printable address, linefeeds on, odd parity, new baud code
    host.send_cmd("$1SU32E20102", -1);
    expect_resp("*", 1'b0, 1'b0, 1'b0);
    `CHK(nv_wdata, 32'h32E20102)
    `CHK(n_we, 1)
    `CHK(write_enabled, 1'b0)
    `CHK(baud_sel, 3'h7)
    host.par_en = 1'b1;
    host.par_odd = 1'b1;
    host.send_cmd("$1RS", -1);
    repeat (40) @(negedge clk);
    `CHK(host.got.size(), 0)
    host.slow = 1'b1;
    host.send_cmd("$2RSU", -1);
    expect_resp("*32E20102", 1'b1, 1'b1, 1'b1);
    host.slow = 1'b0;
    host.send_cmd("$2WE", 3);
    expect_resp("?2 P", 1'b1, 1'b1, 1'b1);
    `CHK(write_enabled, 1'b0)
    host.send_cmd("$2WE", -1);
    expect_resp("*", 1'b1, 1'b1, 1'b1);
    host.send_cmd("$2RR", -1);
    expect_resp("*", 1'b1, 1'b1, 1'b1);
    `CHK(n_restart, 1)
    `CHK(baud_sel, 3'h2)
    // an unlock spent on a read no longer covers a later write
    host.send_cmd("$2WE", -1);
    expect_resp("*", 1'b1, 1'b1, 1'b1);
    host.send_cmd("$2RS", -1);
    expect_resp("*32E20102", 1'b1, 1'b1, 1'b1);
    `CHK(write_enabled, 1'b0)
    host.send_cmd("$2WE", -1);
    expect_resp("*", 1'b1, 1'b1, 1'b1);
    host.send_cmd("$2SU31270102", -1);
    expect_resp("*", 1'b1, 1'b1, 1'b1);
    host.par_odd = 1'b0;
    host.send_cmd("$1RS", -1);
    expect_resp("*31270102", 1'b0, 1'b1, 1'b0);
    `CHK(n_we, 2)
    reset_dut();
    `CHK(nv_wdata, 32'h31270102)
    `CHK(baud_sel, 3'h7)
    `CHK(resp_sum, 8'h00)
    tally_and_finish();
  end
endmodule // testbench
